/* rtl/ffsv_map.vh */
// Register map, field positions, reset values and timing for the fixed-frequency
// sequencer with volts-per-hertz curve. Definitions only; included by bare name.
`ifndef FFSV_MAP_VH
`define FFSV_MAP_VH

// Register byte offsets (APB, one aligned 32-bit word each)
`define FFSV_CTRL 8'h00
`define FFSV_DIR 8'h04
`define FFSV_FUNC 8'h08
`define FFSV_CUTOFF 8'h0c
`define FFSV_VMAX 8'h10
`define FFSV_MIDF 8'h14
`define FFSV_MIDV 8'h18
`define FFSV_BOOST 8'h1c
`define FFSV_MOTV 8'h20
`define FFSV_MOTF 8'h24
`define FFSV_STATUS 8'h28
`define FFSV_VOLT 8'h2c
// Step run times at 8'h40 + 4*n, step frequencies at 8'h60 + 4*n
`define FFSV_STIME_PAGE 3'h2
`define FFSV_SFREQ_PAGE 3'h3

// Control register fields
`define FFSV_F_MODE 2:0
`define FFSV_F_COAST 3
`define FFSV_F_CURVE 5:4
`define FFSV_F_STARTSEL 10:8
`define FFSV_F_PAUSESEL 14:12
// Output function fields
`define FFSV_F_FN0 4:0
`define FFSV_F_FN1 12:8
`define FFSV_F_FN2 20:16

// Sequence modes
`define FFSV_M_OFF 3'h0
`define FFSV_M_ONCE 3'h1
`define FFSV_M_CONT 3'h2
`define FFSV_M_ONCE_STEP 3'h3
`define FFSV_M_CONT_STEP 3'h4
// Curve shapes
`define FFSV_C_LIN 2'h0
`define FFSV_C_SQR 2'h1
`define FFSV_C_CFG 2'h2
// Output function codes
`define FFSV_FN_RUN 5'h10
`define FFSV_FN_STEP 5'h11
`define FFSV_FN_CYCLE 5'h12
`define FFSV_FN_PAUSE 5'h13

// Reset values (frequency in 0.01 Hz, voltage in 0.01 %)
`define FFSV_CTRL_RST 32'h0000_2100
`define FFSV_FUNC_RST 32'h0012_1110
`define FFSV_FREQ_RST 16'h1770
`define FFSV_PCT_RST 16'h2710
// Limits
`define FFSV_CUT_MIN 16'h0bb8
`define FFSV_CUT_MAX 16'h7d00
`define FFSV_VMAX_MIN 16'h03e8
`define FFSV_VMAX_MAX 16'h4e20
`define FFSV_BOOST_MAX 16'h0fa0
`define FFSV_TIME_MAX 10'h3e8
`define FFSV_FULL_SCALE 48'h0000_0000_2710

// Timing: the run-time tick in seconds and the clock period in ns
`define FFSV_TICK_S 1
`define FFSV_CLK_NS 100
`define FFSV_TICK_CYCLES (`FFSV_TICK_S * 1000000000 / `FFSV_CLK_NS)

`endif

/* rtl/ffsv_top.v */
// Fixed-frequency sequencer with volts-per-hertz setpoint and APB register file.
// Assumes one 10 MHz clock, synchronous digital inputs and a downstream ramp and
// modulation stage that reports the actual output frequency.
`timescale 1ns/10ps
`include "ffsv_map.vh"

module ffsv_top #(
  parameter TICK_CYCLES = `FFSV_TICK_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [5:0] digital_inputs,
  input wire [15:0] out_freq,
  output wire run_cmd,
  output wire stop_coast,
  output wire seq_override,
  output reg [15:0] freq_setpoint,
  output reg dir_reverse,
  output reg [15:0] volt_setpoint,
  output wire relay_out_one,
  output wire relay_out_two,
  output wire transistor_out
);

  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_RUN = 4'h2;
  localparam [3:0] S_GAP = 4'h4;
  localparam [3:0] S_DONE = 4'h8;
  localparam integer TICK_M1 = TICK_CYCLES - 1;
  localparam [23:0] TICK_LAST = TICK_M1[23:0];

  reg [31:0] ctrl_reg;
  reg [7:0] dir_reg;
  reg [31:0] func_reg;
  reg [15:0] cut_reg;
  reg [15:0] vmax_reg;
  reg [15:0] midf_reg;
  reg [15:0] midv_reg;
  reg [15:0] boost_reg;
  reg [15:0] motv_reg;
  reg [15:0] motf_reg;
  reg [9:0] time_reg [0:7];
  reg [15:0] sfreq_reg [0:7];
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [2:0] idx_reg;
  reg [2:0] idx_next;
  reg [9:0] sec_reg;
  reg [9:0] sec_next;
  reg [23:0] tick_reg;
  reg [23:0] tick_next;
  reg step_evt_reg;
  reg step_evt_next;
  reg cycle_evt_reg;
  reg cycle_evt_next;
  wire [2:0] mode = ctrl_reg[`FFSV_F_MODE];
  wire [2:0] start_sel = ctrl_reg[`FFSV_F_STARTSEL];
  wire [2:0] pause_sel = ctrl_reg[`FFSV_F_PAUSESEL];
  wire [7:0] active;
  wire wr_en = psel & penable & pwrite;
  wire stime_hit = (paddr[7:5] == `FFSV_STIME_PAGE) && (paddr[1:0] == 2'h0);
  wire sfreq_hit = (paddr[7:5] == `FFSV_SFREQ_PAGE) && (paddr[1:0] == 2'h0);
  wire [2:0] ent = paddr[4:2];
  reg mapped;

  // Clamp a written value into a legal window
  function [15:0] clamp;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // First active step at or after a start position; bit 3 set when one exists
  function [3:0] find_step;
    input [7:0] m;
    input [3:0] from;
    integer i;
    begin
      find_step = 4'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (m[i] && (i >= from)) begin
          find_step = {1'b1, i[2:0]};
        end
      end
    end
  endfunction

  // Level-sensitive selection of the assigned start and pause inputs
  wire start_on = (start_sel != 3'h0) && digital_inputs[start_sel - 3'h1];
  wire pause_on = (pause_sel != 3'h0) && digital_inputs[pause_sel - 3'h1];
  wire seq_live = (state_reg == S_RUN) || (state_reg == S_GAP);
  wire paused = seq_live & pause_on;
  wire stepped = (mode == `FFSV_M_ONCE_STEP) || (mode == `FFSV_M_CONT_STEP);
  wire contin = (mode == `FFSV_M_CONT) || (mode == `FFSV_M_CONT_STEP);
  wire mode_ok = (mode != `FFSV_M_OFF) && (mode <= `FFSV_M_CONT_STEP);
  wire [3:0] first = find_step(active, 4'h0);
  wire [3:0] nxt = find_step(active, {1'b0, idx_reg} + 4'h1);
  wire tick = (tick_reg == TICK_LAST);

  // Per-step activity and register storage, one entry per step
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_step
      assign active[g] = (time_reg[g] != 10'h000);
      always @(posedge clk) begin
        if (rst) begin
          time_reg[g] <= 10'h000;
          sfreq_reg[g] <= 16'h0000;
        end else if (wr_en && (ent == g)) begin
          if (stime_hit) begin
            // Compare the whole word, so large values clamp instead of wrapping
            time_reg[g] <= (pwdata > {22'h000000, `FFSV_TIME_MAX}) ? `FFSV_TIME_MAX : pwdata[9:0];
          end
          if (sfreq_hit) begin
            sfreq_reg[g] <= pwdata[15:0];
          end
        end
      end
    end
  endgenerate

  // Configuration writes; motor ratings also reload the curve rating points
  always @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= `FFSV_CTRL_RST;
      dir_reg <= 8'h00;
      func_reg <= `FFSV_FUNC_RST;
      cut_reg <= `FFSV_FREQ_RST;
      vmax_reg <= `FFSV_PCT_RST;
      midf_reg <= `FFSV_FREQ_RST;
      midv_reg <= `FFSV_PCT_RST;
      boost_reg <= 16'h0000;
      motv_reg <= `FFSV_PCT_RST;
      motf_reg <= `FFSV_FREQ_RST;
    end else if (wr_en) begin
      case (paddr)
        `FFSV_CTRL: ctrl_reg <= {17'h00000, pwdata[14:0]};
        `FFSV_DIR: dir_reg <= pwdata[7:0];
        `FFSV_FUNC: func_reg <= {11'h000, pwdata[20:16], 3'h0, pwdata[12:8], 3'h0, pwdata[4:0]};
        `FFSV_CUTOFF: cut_reg <= clamp(pwdata[15:0], `FFSV_CUT_MIN, `FFSV_CUT_MAX);
        `FFSV_VMAX: vmax_reg <= clamp(pwdata[15:0], `FFSV_VMAX_MIN, `FFSV_VMAX_MAX);
        `FFSV_MIDF: midf_reg <= pwdata[15:0];
        `FFSV_MIDV: midv_reg <= pwdata[15:0];
        `FFSV_BOOST: boost_reg <= clamp(pwdata[15:0], 16'h0000, `FFSV_BOOST_MAX);
        `FFSV_MOTV: begin
          motv_reg <= pwdata[15:0];
          vmax_reg <= clamp(pwdata[15:0], `FFSV_VMAX_MIN, `FFSV_VMAX_MAX);
        end
        `FFSV_MOTF: begin
          motf_reg <= pwdata[15:0];
          cut_reg <= clamp(pwdata[15:0], `FFSV_CUT_MIN, `FFSV_CUT_MAX);
        end
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Sequencer: level start, abandon on release, skip empty steps, pause freezes time
  always @* begin
    state_next = state_reg;
    idx_next = idx_reg;
    sec_next = sec_reg;
    tick_next = tick_reg;
    step_evt_next = 1'b0;
    cycle_evt_next = 1'b0;
    case (state_reg)
      S_IDLE: begin
        if (start_on && mode_ok && first[3]) begin
          state_next = S_RUN;
          idx_next = first[2:0];
          sec_next = 10'h000;
          tick_next = 24'h000000;
        end
      end
      S_RUN: begin
        if (!pause_on) begin
          tick_next = tick ? 24'h000000 : tick_reg + 24'h000001;
          if (tick) begin
            sec_next = sec_reg + 10'h001;
            if (sec_reg + 10'h001 >= time_reg[idx_reg]) begin
              step_evt_next = 1'b1;
              cycle_evt_next = ~nxt[3];
              sec_next = 10'h000;
              // The last step of a single cycle ends at once, with the cycle pulse
              if (stepped && (nxt[3] || contin)) begin
                state_next = S_GAP;
              end else if (nxt[3]) begin
                idx_next = nxt[2:0];
              end else if (contin) begin
                idx_next = first[2:0];
              end else begin
                state_next = S_DONE;
              end
            end
          end
        end
      end
      S_GAP: begin
        // Wait until the drive has actually reached zero before the next step
        if (!pause_on && (out_freq == 16'h0000)) begin
          tick_next = 24'h000000;
          if (nxt[3]) begin
            idx_next = nxt[2:0];
            state_next = S_RUN;
          end else if (contin) begin
            idx_next = first[2:0];
            state_next = S_RUN;
          end else begin
            state_next = S_DONE;
          end
        end
      end
      S_DONE: state_next = S_DONE;
      default: state_next = S_IDLE;
    endcase
    // Losing start ends everything from any state; stays off until a new start
    if (!start_on || !mode_ok) begin
      state_next = S_IDLE;
      idx_next = 3'h0;
      sec_next = 10'h000;
      tick_next = 24'h000000;
    end
    if (state_reg == S_IDLE) begin
      step_evt_next = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      idx_reg <= 3'h0;
      sec_reg <= 10'h000;
      tick_reg <= 24'h000000;
      step_evt_reg <= 1'b0;
      cycle_evt_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      sec_reg <= sec_next;
      tick_reg <= tick_next;
      step_evt_reg <= step_evt_next;
      cycle_evt_reg <= cycle_evt_next;
    end
  end

  // Setpoint zero outside a running, unpaused step; direction always follows the next step index
  always @(posedge clk) begin
    if (rst) begin
      freq_setpoint <= 16'h0000;
      dir_reverse <= 1'b0;
    end else begin
      freq_setpoint <= (state_next == S_RUN && !pause_on) ? sfreq_reg[idx_next] : 16'h0000;
      dir_reverse <= dir_reg[idx_next];
    end
  end

  // Run command drops during gaps, pause and after release; stop style from control
  assign run_cmd = (state_reg == S_RUN) & ~pause_on;
  assign stop_coast = ctrl_reg[`FFSV_F_COAST];
  assign seq_override = seq_live;

  // Output function decode, the same for each of the three status outputs
  wire [2:0] dout;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_out
      wire [4:0] fn = func_reg[g * 8 +: 5];
      assign dout[g] = (fn == `FFSV_FN_RUN) ? seq_live :
                       (fn == `FFSV_FN_STEP) ? step_evt_reg :
                       (fn == `FFSV_FN_CYCLE) ? cycle_evt_reg :
                       (fn == `FFSV_FN_PAUSE) ? paused : 1'b0;
    end
  endgenerate
  assign relay_out_one = dout[0];
  assign relay_out_two = dout[1];
  assign transistor_out = dout[2];

  // Volts-per-hertz: shape = base + span * ratio, base set by boost
  // Division is combinational; the result is registered, giving one cycle latency
  wire [47:0] f = {32'h0, out_freq};
  wire [47:0] fc = {32'h0, cut_reg};
  wire [47:0] vm = {32'h0, vmax_reg};
  wire [47:0] base = vm * {32'h0, boost_reg} / `FFSV_FULL_SCALE;
  wire [47:0] mf = (midf_reg > cut_reg) ? fc : {32'h0, midf_reg};
  wire [47:0] mv = (midv_reg < base[15:0]) ? base :
                   ((midv_reg > vmax_reg) ? vm : {32'h0, midv_reg});
  reg [47:0] v;
  always @* begin
    v = vm;
    if (f < fc) begin
      case (ctrl_reg[`FFSV_F_CURVE])
        `FFSV_C_LIN: v = base + (vm - base) * f / fc;
        `FFSV_C_SQR: v = base + (vm - base) * f * f / (fc * fc);
        `FFSV_C_CFG: begin
          if (f < mf) begin
            v = base + (mv - base) * f / mf;
          end else begin
            v = mv + (vm - mv) * (f - mf) / (fc - mf);
          end
        end
        default: v = base + (vm - base) * f / fc;
      endcase
    end else begin
      v = vm;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      volt_setpoint <= 16'h0000;
    end else begin
      volt_setpoint <= v[15:0];
    end
  end

  // APB slave: no wait states, read data captured in the setup cycle
  always @* begin
    mapped = stime_hit | sfreq_hit;
    case (paddr)
      `FFSV_CTRL, `FFSV_DIR, `FFSV_FUNC, `FFSV_CUTOFF, `FFSV_VMAX, `FFSV_MIDF,
      `FFSV_MIDV, `FFSV_BOOST, `FFSV_MOTV, `FFSV_MOTF, `FFSV_STATUS, `FFSV_VOLT: mapped = 1'b1;
      default: mapped = stime_hit | sfreq_hit;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped; // Unmapped or misaligned offset

  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      if (stime_hit) begin
        prdata <= {22'h000000, time_reg[ent]};
      end else if (sfreq_hit) begin
        prdata <= {16'h0000, sfreq_reg[ent]};
      end else begin
        case (paddr)
          `FFSV_CTRL: prdata <= ctrl_reg;
          `FFSV_DIR: prdata <= {24'h000000, dir_reg};
          `FFSV_FUNC: prdata <= func_reg;
          `FFSV_CUTOFF: prdata <= {16'h0000, cut_reg};
          `FFSV_VMAX: prdata <= {16'h0000, vmax_reg};
          `FFSV_MIDF: prdata <= {16'h0000, midf_reg};
          `FFSV_MIDV: prdata <= {16'h0000, midv_reg};
          `FFSV_BOOST: prdata <= {16'h0000, boost_reg};
          `FFSV_MOTV: prdata <= {16'h0000, motv_reg};
          `FFSV_MOTF: prdata <= {16'h0000, motf_reg};
          `FFSV_STATUS: prdata <= {12'h000, sec_reg, state_reg, dir_reverse, idx_reg, paused, seq_live};
          `FFSV_VOLT: prdata <= {16'h0000, volt_setpoint};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // ffsv_top

/* dv/ffsv_monitor.sv */
// Checker for the sequencer outputs of ffsv_top.
// Assumes start on input 1 and pause on input 2, the reset choice of the select fields.
`timescale 1ns/10ps
`include "ffsv_map.vh"
module ffsv_monitor (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [5:0] digital_inputs,
  input wire [15:0] out_freq,
  input wire run_cmd,
  input wire seq_override,
  input wire [15:0] freq_setpoint,
  input wire relay_out_two,
  input wire transistor_out
);
  reg [31:0] fn_reg;
  wire fn17 = fn_reg[12:8] == `FFSV_FN_STEP;
  wire fn18 = fn_reg[20:16] == `FFSV_FN_CYCLE;
  wire fn19 = fn_reg[20:16] == `FFSV_FN_PAUSE;
  wire gap_now = seq_override && !run_cmd && !digital_inputs[1];
  // Mirror of the function word, so pulse checks only apply where the output shows that event
  always @(posedge clk) begin
    if (rst) fn_reg <= `FFSV_FUNC_RST;
    else if (psel && penable && pwrite && pready && paddr == `FFSV_FUNC) fn_reg <= pwdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence pause_held;
    digital_inputs[1] [*3];
  endsequence
  // Pause release is excluded: the registered setpoint lags the pause input by one cycle
  sequence gap_seen;
    gap_now && !$past(digital_inputs[1]);
  endsequence
  start_drop_a: assert property (!digital_inputs[0] |=> !seq_override)
    else $error("sequence live after start dropped");
  pause_stop_a: assert property (pause_held |-> !run_cmd && freq_setpoint == 16'h0)
    else $error("drive running while paused");
  run_override_a: assert property (run_cmd |-> seq_override)
    else $error("run without sequence override");
  step_pulse_a: assert property (fn17 && relay_out_two |=> !relay_out_two)
    else $error("step expiry pulse too long");
  cycle_end_a: assert property (fn17 && fn18 && transistor_out |-> relay_out_two)
    else $error("cycle end without last step expiry");
  pause_flag_a: assert property (fn19 && transistor_out |-> digital_inputs[1] || $past(digital_inputs[1]))
    else $error("pause output without pause input");
  gap_zero_a: assert property (gap_seen ##1 gap_seen |-> freq_setpoint == 16'h0)
    else $error("setpoint not zero between steps");
  gap_wait_a: assert property (gap_seen and out_freq != 16'h0 |=> !run_cmd)
    else $error("next step before output reached zero");
endmodule // ffsv_monitor

bind ffsv_top ffsv_monitor i_ffsv_monitor (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata), .digital_inputs(digital_inputs),
  .out_freq(out_freq), .run_cmd(run_cmd), .seq_override(seq_override), .freq_setpoint(freq_setpoint),
  .relay_out_two(relay_out_two), .transistor_out(transistor_out));

/* dv/ffsv_ramp_model.sv */
// Ramp stage model: walks the actual output frequency toward the setpoint.
// Assumes setpoints in 0.01 Hz well below the 16-bit limit.
`timescale 1ns/10ps
module ffsv_ramp_model #(
  parameter SLOPE = 16'h00fa
) (
  input wire clk,
  input wire rst,
  input wire run_cmd,
  input wire stop_coast,
  input wire [15:0] freq_setpoint,
  output reg [15:0] out_freq
);
  wire [15:0] target = run_cmd ? freq_setpoint : 16'h0;
  // Coast drops at once; a ramped stop takes cycles, so gaps really wait for zero
  always @(posedge clk) begin
    if (rst || (stop_coast && !run_cmd)) out_freq <= 16'h0;
    else if (out_freq + SLOPE < target) out_freq <= out_freq + SLOPE;
    else if (out_freq > target + SLOPE) out_freq <= out_freq - SLOPE;
    else out_freq <= target;
  end
endmodule // ffsv_ramp_model

/* dv/tb.sv */
// Self-checking bench for ffsv_top: registers, curve and all sequence modes.
// Assumes the ramp model on the far side and a shortened run-time tick.
`timescale 1ns/10ps
`include "ffsv_map.vh"
module tb;
  localparam TICK = 10;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [5:0] din = 6'h00;
  reg force_f = 1'b1;
  reg [15:0] f_val = 16'h0;
  reg [15:0] last_sp = 16'h0;
  reg [2:0] mode = 3'h0;
  wire [31:0] prdata;
  wire pready, pslverr, run_cmd, stop_coast, seq_override, dir_reverse, relay_out_one, relay_out_two, transistor_out;
  wire [15:0] freq_setpoint, volt_setpoint, ramp_f;
  wire [15:0] out_freq = force_f ? f_val : ramp_f;
  integer n_errors = 0, n_checks = 0, seed = 32'h78b3fea1, cnt = 0, ncyc = 0, m, i, fr;
  reg [32:0] rq[$];
  reg [16:0] sq[$];
  integer dq[$];
  reg [7:0] ra [0:9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
  reg [31:0] rv [0:9] = '{32'h2100, 32'h0, 32'h121110, 32'h1770, 32'h2710, 32'h1770, 32'h2710, 32'h0, 32'h2710,
    32'h1770};
  // Write address, read address, data, expected read
  reg [47:0] ct [0:9] = '{48'h0c0c_03e8_0bb8, 48'h0c0c_9c40_7d00, 48'h1010_01f4_03e8, 48'h1010_c350_4e20,
    48'h5c5c_07d0_03e8, 48'h240c_1b58_1b58, 48'h2010_2ee0_2ee0, 48'h3c3c_0005_0000, 48'h240c_1770_1770,
    48'h2010_2710_2710};
  // Curve, max, boost, mid f, mid v, f, expected volts
  reg [111:0] vt [0:7] = '{112'h0_2710_0000_1770_2710_0bb8_1388, 112'h0_2710_0000_1770_2710_2328_2710,
    112'h1_2710_0000_1770_2710_0bb8_09c4, 112'h0_2710_03e8_1770_2710_0bb8_157c,
    112'h2_2710_0000_0bb8_1f40_05dc_0fa0, 112'h2_2710_0000_0bb8_1f40_1194_2328,
    112'h0_1388_0000_1770_2710_0bb8_09c4, 112'h0_2710_0000_1770_2710_0000_0000};
  always #50 clk = ~clk;
  ffsv_top #(.TICK_CYCLES(TICK)) i_ffsv_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .digital_inputs(din), .out_freq(out_freq), .run_cmd(run_cmd), .stop_coast(stop_coast),
    .seq_override(seq_override), .freq_setpoint(freq_setpoint), .dir_reverse(dir_reverse),
    .volt_setpoint(volt_setpoint), .relay_out_one(relay_out_one), .relay_out_two(relay_out_two),
    .transistor_out(transistor_out));
  ffsv_ramp_model i_ffsv_ramp_model (.clk(clk), .rst(rst), .run_cmd(run_cmd), .stop_coast(stop_coast),
    .freq_setpoint(freq_setpoint), .out_freq(ramp_f));
  task check(input string name, input [32:0] exp, input [32:0] got);
    begin
      n_checks = n_checks + 1;
      if (exp !== got) begin
        n_errors = n_errors + 1;
        $display("Error %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Setup cycle, then access held until ready is seen high
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [32:0] x);
    begin
      rq.push_back(x);
      apb(1'b0, a, 32'h0);
    end
  endtask
  // Three active steps with a pause in the first; continuous modes run into a second cycle
  task run_prog(input [2:0] md);
    begin
      mode = md;
      apb(1'b1, `FFSV_FUNC, md < 3 ? 32'h0013_1110 : `FFSV_FUNC_RST);
      sq = '{17'h003e8, 17'h003e8, 17'h10a28, 17'h10bb8};
      dq = '{2, 1, 1};
      if (md == 2 || md == 4) begin
        sq.push_back(17'h003e8);
        sq.push_back(17'h10a28);
        dq.push_back(2);
      end
      ncyc = 0;
      din <= 6'h01;
      apb(1'b1, `FFSV_CTRL, 32'h2100 | {md == 4, md});
      tick(8);
      din[1] <= 1'b1;
      tick(12);
      #1 check("paused", {md < 3, 1'b0}, {transistor_out, run_cmd});
      @(posedge clk) din[1] <= 1'b0;
      while (sq.size() != 0 || dq.size() != 0) @(posedge clk);
      tick(3);
      #1 check("run_out", md == 2 || md == 4, relay_out_one);
      @(posedge clk) din[0] <= 1'b0;
      tick(2);
      #1 check("abandon", {2'b00, md == 4}, {relay_out_one, seq_override, stop_coast});
      check("cycles", md > 2, ncyc);
      sq.push_back(17'h003e8);
      @(posedge clk) din[0] <= 1'b1;
      while (sq.size() != 0) @(posedge clk);
      tick(3);
      din[0] <= 1'b0;
      tick(3);
      $display("test mode %0d done", md);
    end
  endtask
  // Scoreboard: each result as it appears is paired with the oldest note
  always @(posedge clk) begin
    if (!rst) begin
      if (psel && penable && pready && !pwrite) check("prdata", rq.pop_front(), {pslverr, prdata});
      if (freq_setpoint !== last_sp && freq_setpoint !== 16'h0) check("step", sq.pop_front(), {dir_reverse, freq_setpoint});
      last_sp <= freq_setpoint;
      // Judge the expiry before counting this edge: the last step may already have left the run state
      if (relay_out_two) begin
        check("step_len", 1, cnt >= dq[0] * TICK - 1 && cnt <= dq[0] * TICK + 1);
        void'(dq.pop_front());
        cnt = 0;
      end
      if (!seq_override) cnt = 0;
      else if (run_cmd) cnt = cnt + 1;
      if (transistor_out && mode > 2) ncyc = ncyc + 1;
    end
  end
  initial begin
    tick(20);
    rst <= 1'b0;
    for (i = 0; i < 10; i = i + 1) rd(ra[i], {1'b0, rv[i]});
    for (i = 0; i < 10; i = i + 1) begin
      apb(1'b1, ct[i][47:40], {16'h0, ct[i][31:16]});
      rd(ct[i][39:32], {ct[i][47:40] == 8'h3c, 16'h0, ct[i][15:0]});
    end
    $display("test registers done");
    for (i = 0; i < 8; i = i + 1) begin
      apb(1'b1, `FFSV_VMAX, {16'h0, vt[i][95:80]});
      apb(1'b1, `FFSV_BOOST, {16'h0, vt[i][79:64]});
      apb(1'b1, `FFSV_MIDF, {16'h0, vt[i][63:48]});
      apb(1'b1, `FFSV_MIDV, {16'h0, vt[i][47:32]});
      apb(1'b1, `FFSV_CTRL, 32'h2100 | {vt[i][97:96], 4'h0});
      f_val <= vt[i][31:16];
      tick(3);
      #1 check("volt", vt[i][15:0], volt_setpoint);
    end
    for (i = 0; i < 8; i = i + 1) begin
      fr = ($unsigned($random(seed)) % 2000) * 3;
      @(posedge clk) f_val <= 16'(fr);
      tick(3);
      #1 check("volt_rand", 33'(fr * 5 / 3), volt_setpoint);
    end
    rd(`FFSV_VOLT, {17'h0, 16'(fr * 5 / 3)});
    rd(`FFSV_STATUS, 33'h40);
    $display("test curve done");
    for (i = 0; i < 8; i = i + 1) begin
      apb(1'b1, 8'(8'h40 + 4 * i), i == 0 ? 32'h2 : {31'h0, i > 5});
      apb(1'b1, 8'(8'h60 + 4 * i), i == 0 ? 32'h3e8 : i == 6 ? 32'ha28 : 32'hbb8);
    end
    apb(1'b1, `FFSV_DIR, 32'hc0);
    @(posedge clk) force_f <= 1'b0;
    din <= 6'h01;
    apb(1'b1, `FFSV_CTRL, 32'h2100);
    tick(5);
    #1 check("mode_off", 0, seq_override);
    @(posedge clk) din <= 6'h00;
    for (m = 1; m < 5; m = m + 1) run_prog(3'(m));
    test_done;
  end
  initial begin
    #(30000 * 100);
    n_errors = n_errors + 1;
    test_done;
  end
endmodule // tb
